// [verif/dual_reload_timer_pulse_gen_monitor.sv]
// Checker of bus handshakes and timer outputs
module dual_reload_timer_pulse_gen_monitor (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Bus handshakes
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Timer outputs
  input wire logic        pulse_out_pin,
  input wire logic        irq,
  input wire logic [15:0] irq_vector
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Fixed vector address
  property p_vector; irq_vector == 16'h002B; endproperty
  a_vector: assert property (p_vector) else $error("vector address wrong");
  // Outputs cleared out of reset
  property p_reset_clear; $rose(aresetn) |-> !irq && !pulse_out_pin && !s_axi_bvalid && !s_axi_rvalid; endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("outputs not clear after reset");
  // Write channels share one ready
  property p_aw_w; s_axi_awready == s_axi_wready; endproperty
  a_aw_w: assert property (p_aw_w) else $error("awready and wready differ");
  property p_aw_pulse; s_axi_awready |=> !s_axi_awready; endproperty
  a_aw_pulse: assert property (p_aw_pulse) else $error("awready longer than one cycle");
  // Answers one cycle after acceptance
  property p_b_follows; s_axi_awready |=> s_axi_bvalid; endproperty
  a_b_follows: assert property (p_b_follows) else $error("write response late");
  property p_r_follows; s_axi_arready |=> s_axi_rvalid; endproperty
  a_r_follows: assert property (p_r_follows) else $error("read response late");
  // Answers held until taken
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read response dropped");
  // No new write while a response waits
  property p_b_refuse; s_axi_bvalid |-> !s_axi_awready; endproperty
  a_b_refuse: assert property (p_b_refuse) else $error("write taken during response");
  // Registers are one byte wide
  property p_r_upper; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000; endproperty
  a_r_upper: assert property (p_r_upper) else $error("upper read bits set");
  // Main scenarios
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_irq: cover property ($rose(irq));
  c_pulse: cover property ($fell(pulse_out_pin));
endmodule : dual_reload_timer_pulse_gen_monitor

bind dual_reload_timer_pulse_gen dual_reload_timer_pulse_gen_monitor u_mon (.aclk, .aresetn, .s_axi_awready,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .pulse_out_pin, .irq, .irq_vector);

// [verif/dual_reload_timer_pulse_gen_tb_top.sv]
// Self-checking testbench for the dual reload timer and pulse generator
module dual_reload_timer_pulse_gen_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // Register byte addresses
  localparam logic [11:0] A_CTL = {timer_pkg::IDX_CONTROL, 2'b00};
  localparam logic [11:0] A_LC  = {timer_pkg::IDX_LOW_COMPARE, 2'b00};
  localparam logic [11:0] A_LOW = {timer_pkg::IDX_LOW, 2'b00};
  localparam logic [11:0] A_HC  = {timer_pkg::IDX_HIGH_COMPARE, 2'b00};
  localparam logic [11:0] A_HI  = {timer_pkg::IDX_HIGH, 2'b00};
  localparam logic [11:0] A_PIN = {timer_pkg::IDX_PIN_CONTROL, 2'b00};
  // Clock, reset and bus signals
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, pulse_out_pin, irq;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, wresp, rresp;
  logic [15:0] irq_vector;
  // Cycle count and scoring
  int          cyc, error_cnt, total_checks;

  dual_reload_timer_pulse_gen DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pulse_out_pin,
    .irq, .irq_vector);

  // Free-running clock
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  // Cycle counter for period measurement
  always @(posedge aclk) cyc <= cyc + 1;

  // Compare one value
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check

  // Bus write of one byte
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_awready);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_bvalid);
    wresp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  // Bus read of one word
  task automatic rd(input logic [11:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    rdat = s_axi_rdata;
    rresp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  // Wait for interrupt high, return cycle
  task automatic wait_irq(output int t);
    do @(posedge aclk); while (irq !== 1'b1);
    t = cyc;
  endtask : wait_irq

  // Interval between two interrupts
  task automatic t_period(input logic [7:0] ctl, input int exp);
    int t0, t1;
    wr(A_CTL, ctl);
    wait_irq(t0);
    wr(A_CTL, ctl);
    wait_irq(t1);
    check("irq period", exp, t1 - t0);
    wr(A_CTL, 8'h00);
  endtask : t_period

  // Reset values, unmapped address, vector
  task automatic t_reset;
    logic [11:0] regs [6] = '{A_CTL, A_LC, A_LOW, A_HC, A_HI, A_PIN};
    foreach (regs[i]) begin
      rd(regs[i]);
      check("reset value", 32'h0, rdat);
    end
    rd(12'h47C);
    check("unmapped rresp", {30'h0, timer_pkg::RESP_SLVERR}, {30'h0, rresp});
    wr(12'h47C, 8'h5A);
    check("unmapped bresp", {30'h0, timer_pkg::RESP_SLVERR}, {30'h0, wresp});
    check("vector", 32'h002B, {16'h0, irq_vector});
    $display("test reset done");
  endtask : t_reset

  // Two 8-bit timers, masking and stop reload
  task automatic t_dual;
    wr(A_LOW, 8'hE0);
    t_period(8'h41, 32);
    rd(A_LOW);
    check("low reload on stop", 32'hE0, rdat);
    wr(A_HI, 8'hC0);
    t_period(8'h84, 64);
    rd(A_HI);
    check("high reload on stop", 32'hC0, rdat);
    wr(A_CTL, 8'h40);
    repeat (40) @(posedge aclk);
    check("masked irq", 32'h0, {31'h0, irq});
    rd(A_CTL);
    check("low flag kept", 32'h42, rdat);
    wr(A_CTL, 8'h00);
    $display("test dual done");
  endtask : t_dual

  // Cascaded 16-bit timer at full and half rate
  task automatic t_cascade;
    wr(A_LOW, 8'hF8);
    wr(A_HI, 8'hFC);
    t_period(8'hE4, 32);
    t_period(8'h64, 64);
    $display("test cascade done");
  endtask : t_cascade

  // Low and high cycles of one pulse
  task automatic meas(output int lo, output int hi);
    do @(posedge aclk); while (!pulse_out_pin);
    do @(posedge aclk); while (pulse_out_pin);
    lo = 0;
    hi = 0;
    do begin lo++; @(posedge aclk); end while (!pulse_out_pin);
    do begin hi++; @(posedge aclk); end while (pulse_out_pin);
  endtask : meas

  // 8-bit pulse generator and pin selection
  task automatic t_pulse;
    int lo, hi;
    wr(A_PIN, 8'h02);
    repeat (3) @(posedge aclk);
    check("port data on pin", 32'h1, {31'h0, pulse_out_pin});
    wr(A_PIN, 8'h01);
    wr(A_LOW, 8'hF0);
    wr(A_LC, 8'hF4);
    wr(A_CTL, 8'h40);
    meas(lo, hi);
    check("low width", 32'd4, lo);
    check("pulse period", 32'd16, lo + hi);
    wr(A_LC, 8'hF8);
    meas(lo, hi);
    check("compare held", 32'd4, lo);
    wr(A_CTL, 8'h50);
    meas(lo, hi); // Period in flight may be old
    meas(lo, hi);
    check("compare updated", 32'd8, lo);
    wr(A_CTL, 8'h00);
    $display("test pulse done");
  endtask : t_pulse

  // Variable length pulse: total low time over one large period
  task automatic t_var(input logic [7:0] hr, lc, hc, input int per, exp);
    int n;
    wr(A_CTL, 8'h00);
    wr(A_HI, hr);
    wr(A_LOW, 8'h00);
    wr(A_LC, lc);
    wr(A_HC, hc);
    wr(A_CTL, 8'hE0);
    repeat (per) @(posedge aclk);
    n = 0;
    repeat (per) begin
      @(posedge aclk);
      if (pulse_out_pin === 1'b0) n++;
    end
    check("total low time", exp, n);
    rd(A_CTL);
    check("both flags", 32'hEA, rdat);
    $display("test variable done");
  endtask : t_var

  // Final counts and verdict
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results

  // Watchdog against hangs
  initial begin
    repeat (60000) @(posedge aclk);
    error_cnt++;
    results();
  end

  // Main sequence
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    {cyc, error_cnt, total_checks} = '0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_dual();
    t_cascade();
    t_pulse();
    t_var(8'hFE, 8'h03, 8'h80, 512, 7);
    t_var(8'hFE, 8'h03, 8'hFF, 512, 7);
    t_var(8'hC0, 8'h02, 8'h17, 16384, 133);
    results();
  end
endmodule : dual_reload_timer_pulse_gen_tb_top

// [verilog/dual_reload_timer_pulse_gen.sv]
// Dual 8-bit reload timer with pulse generator behind an AXI4-Lite slave
//
// Chosen here: the placing of the registers and the AXI4-Lite slave port.
module dual_reload_timer_pulse_gen (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Write address channel
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // Write data channel
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // Write response channel
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // Read address channel
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // Read data channel
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Timer outputs
  output logic             pulse_out_pin,
  output logic             irq,
  output logic [15:0]      irq_vector
);

  // Register map, one byte in each word
  // Control: run, width, update, flags
  // Low compare: low compare value
  // Low: reload on write, count on read
  // High compare: high compare value
  // High: reload on write, count on read
  // Pin control: pin function, port data
  // Unmapped or misaligned: SLVERR, no store
  // Upper read bits always zero

  // Bus handshake state
  logic        awready_ff;      // Address and data taken together
  logic        bvalid_ff;       // Write answer pending
  logic [1:0]  bresp_ff;        // Write answer code
  logic        arready_ff;      // Read address taken
  logic        rvalid_ff;       // Read answer pending
  logic [1:0]  rresp_ff;        // Read answer code
  logic [31:0] rdata_ff;        // Read answer data
  logic        nxt_awready;
  logic        nxt_bvalid;
  logic [1:0]  nxt_bresp;
  logic        nxt_arready;
  logic        nxt_rvalid;
  logic [1:0]  nxt_rresp;
  logic [31:0] nxt_rdata;

  // Timer state
  logic [7:0]  control_ff;      // Timer control register
  logic [7:0]  high_reload_ff;  // High counter reload
  logic [7:0]  low_reload_ff;   // Low counter reload
  logic [7:0]  low_compare_ff;  // Software low compare
  logic [7:0]  high_compare_ff; // Software high compare
  logic [7:0]  high_counter_ff; // High up-counter
  logic [7:0]  low_counter_ff;  // Low up-counter
  logic [7:0]  act_low_cmp_ff;  // Low compare seen by comparator
  logic [7:0]  act_high_cmp_ff; // High compare seen by comparator
  logic        half_ff;         // Half-rate clock phase
  logic [1:0]  pin_control_ff;  // Pin function and port data
  logic        pulse_ff;        // Generator waveform
  logic        pin_ff;          // Pin level
  logic        irq_ff;          // Interrupt request
  logic [15:0] vector_ff;       // Vector address
  logic [7:0]  nxt_control;
  logic [7:0]  nxt_high_reload;
  logic [7:0]  nxt_low_reload;
  logic [7:0]  nxt_low_compare;
  logic [7:0]  nxt_high_compare;
  logic [7:0]  nxt_high_counter;
  logic [7:0]  nxt_low_counter;
  logic [7:0]  nxt_act_low_cmp;
  logic [7:0]  nxt_act_high_cmp;
  logic        nxt_half;
  logic [1:0]  nxt_pin_control;
  logic        nxt_pulse;
  logic        nxt_pin;
  logic        nxt_irq;
  logic [15:0] nxt_vector;

  // Helpers rebuilt every cycle
  // Decoded controls and timer events
  logic        wr_fire;         // Write handshake this cycle
  logic        wr_ok;           // Write hits a mapped register
  logic [9:0]  wr_idx;          // Write register index
  logic [9:0]  rd_idx;          // Read register index
  logic        high_run;
  logic        low_run;
  logic        long_mode;
  logic        low_tick;        // Low counter advances
  logic        high_tick;       // High counter advances
  logic        low_ovf;         // Low counter wraps
  logic        high_ovf;        // High counter wraps
  logic [7:0]  period_idx;      // Small period index in large period
  logic [8:0]  period_cnt;      // Small periods per large period
  logic [16:0] extra_prod;      // Scaled high compare
  logic        extra_low;       // This small period is one clock wider
  logic [8:0]  low_limit;       // Low time of current small period

  // Vector too, so every output is a flop
  // Outputs straight from flip-flops
  assign s_axi_awready = awready_ff;
  assign s_axi_wready  = awready_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rresp   = rresp_ff;
  assign s_axi_rdata   = rdata_ff;
  assign pulse_out_pin = pin_ff;
  assign irq           = irq_ff;
  assign irq_vector    = vector_ff;

  // Write taken only with address and data valid
  // Ready pulses one cycle per taken request
  // Answer rises the cycle after the taking edge
  // Answer and code held until the master takes them
  // Pending answer blocks the next request of its kind

  // Bus slave next state
  always_comb begin
    wr_idx      = s_axi_awaddr[11:2];
    rd_idx      = s_axi_araddr[11:2];
    wr_fire     = awready_ff & s_axi_awvalid & s_axi_wvalid;
    wr_ok       = (s_axi_awaddr[1:0] == 2'h0) &&
                  (wr_idx == timer_pkg::IDX_CONTROL || wr_idx == timer_pkg::IDX_LOW_COMPARE ||
                   wr_idx == timer_pkg::IDX_LOW || wr_idx == timer_pkg::IDX_HIGH_COMPARE ||
                   wr_idx == timer_pkg::IDX_HIGH || wr_idx == timer_pkg::IDX_PIN_CONTROL);
    // Take address and data only when both are offered
    nxt_awready = s_axi_awvalid & s_axi_wvalid & ~awready_ff & ~bvalid_ff;
    nxt_bvalid  = bvalid_ff;
    nxt_bresp   = bresp_ff;
    if (wr_fire) begin
      // Answer follows the taken write
      nxt_bvalid = 1'b1;
      nxt_bresp  = wr_ok ? timer_pkg::RESP_OKAY : timer_pkg::RESP_SLVERR;
    end else if (bvalid_ff && s_axi_bready) begin
      // Answer collected
      nxt_bvalid = 1'b0;
    end
    nxt_arready = s_axi_arvalid & ~arready_ff & ~rvalid_ff;
    nxt_rvalid  = rvalid_ff;
    nxt_rresp   = rresp_ff;
    nxt_rdata   = rdata_ff;
    if (arready_ff && s_axi_arvalid) begin
      // Sample the addressed register
      nxt_rvalid = 1'b1;
      nxt_rresp  = timer_pkg::RESP_OKAY;
      nxt_rdata  = 32'h0000_0000;
      if (s_axi_araddr[1:0] != 2'h0) begin
        nxt_rresp = timer_pkg::RESP_SLVERR;
      end else begin
        // Reload words read back the live count
        unique case (rd_idx)
          timer_pkg::IDX_CONTROL:      nxt_rdata[7:0] = control_ff;
          timer_pkg::IDX_LOW_COMPARE:  nxt_rdata[7:0] = low_compare_ff;
          timer_pkg::IDX_LOW:          nxt_rdata[7:0] = low_counter_ff;
          timer_pkg::IDX_HIGH_COMPARE: nxt_rdata[7:0] = high_compare_ff;
          timer_pkg::IDX_HIGH:         nxt_rdata[7:0] = high_counter_ff;
          timer_pkg::IDX_PIN_CONTROL:  nxt_rdata[1:0] = pin_control_ff;
          default:                     nxt_rresp      = timer_pkg::RESP_SLVERR;
        endcase
      end
    end else if (rvalid_ff && s_axi_rready) begin
      // Read data collected
      nxt_rvalid = 1'b0;
    end
  end

  // Reset leaves no ready and no answer pending
  // Read data holds the last answer
  // Bus slave registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= timer_pkg::RESP_OKAY;
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rresp_ff   <= timer_pkg::RESP_OKAY;
      rdata_ff   <= 32'h0000_0000;
    end else begin
      awready_ff <= nxt_awready;
      bvalid_ff  <= nxt_bvalid;
      bresp_ff   <= nxt_bresp;
      arready_ff <= nxt_arready;
      rvalid_ff  <= nxt_rvalid;
      rresp_ff   <= nxt_rresp;
      rdata_ff   <= nxt_rdata;
    end
  end

  // Low counter steps each cycle in 8-bit mode
  // Half rate: low counter steps every other cycle
  // Half-rate phase rests at zero when unused
  // Overflow is a step taken from the top count
  // Long mode: high counter steps on low overflow

  // Timer next state
  always_comb begin
    high_run  = control_ff[timer_pkg::CTL_HIGH_RUN];
    low_run   = control_ff[timer_pkg::CTL_LOW_RUN];
    long_mode = control_ff[timer_pkg::CTL_LONG_MODE];

    // Half rate toggles only in long mode with high run clear
    nxt_half  = (long_mode & low_run & ~high_run) ? ~half_ff : 1'b0;
    // Low counter: every cycle in 8-bit mode, full or half rate in long mode
    low_tick  = low_run & (~long_mode | high_run | half_ff);
    low_ovf   = low_tick & (low_counter_ff == timer_pkg::COUNTER_TOP);
    // High counter: own run bit in 8-bit mode, low overflow in long mode
    high_tick = long_mode ? low_ovf : high_run;
    high_ovf  = high_tick & (high_counter_ff == timer_pkg::COUNTER_TOP);

    // Overflow reload beats the plain step
    // Low counter
    if (!low_run) begin
      nxt_low_counter = low_reload_ff;
    end else if (low_ovf) begin
      nxt_low_counter = low_reload_ff;
    end else if (low_tick) begin
      nxt_low_counter = low_counter_ff + timer_pkg::COUNT_STEP;
    end else begin
      nxt_low_counter = low_counter_ff;
    end

    // In 8-bit mode its own run bit controls it
    // High counter; in long mode the low run bit holds all 16 bits
    if (long_mode ? !low_run : !high_run) begin
      nxt_high_counter = high_reload_ff;
    end else if (high_ovf) begin
      nxt_high_counter = high_reload_ff;
    end else if (high_tick) begin
      nxt_high_counter = high_counter_ff + timer_pkg::COUNT_STEP;
    end else begin
      nxt_high_counter = high_counter_ff;
    end

    // Writes with lane zero disabled store nothing
    // Reload words take writes, counters are read
    // Software writes
    nxt_control      = control_ff;
    nxt_high_reload  = high_reload_ff;
    nxt_low_reload   = low_reload_ff;
    nxt_low_compare  = low_compare_ff;
    nxt_high_compare = high_compare_ff;
    nxt_pin_control  = pin_control_ff;
    if (wr_fire && wr_ok && s_axi_wstrb[0]) begin
      unique case (wr_idx)
        timer_pkg::IDX_CONTROL:      nxt_control      = s_axi_wdata[7:0];
        timer_pkg::IDX_LOW_COMPARE:  nxt_low_compare  = s_axi_wdata[7:0];
        timer_pkg::IDX_LOW:          nxt_low_reload   = s_axi_wdata[7:0];
        timer_pkg::IDX_HIGH_COMPARE: nxt_high_compare = s_axi_wdata[7:0];
        timer_pkg::IDX_HIGH:         nxt_high_reload  = s_axi_wdata[7:0];
        default:                     nxt_pin_control  = s_axi_wdata[1:0];
      endcase
    end
    // Software clears a flag by writing zero
    // Flags set by hardware or by a software write of one; a hardware set beats a clear in the same cycle
    if (low_ovf) begin
      nxt_control[timer_pkg::CTL_LOW_OVF] = 1'b1;
    end
    if (high_ovf) begin
      nxt_control[timer_pkg::CTL_HIGH_OVF] = 1'b1;
    end

    // Stopped: copy follows the registers
    // Running: copy only at a period end
    // Period end: low overflow, or high in long mode
    // Clear update enable to freeze the copy
    // Comparator data: follows registers while stopped, else at period end
    if (!low_run) begin
      nxt_act_low_cmp  = low_compare_ff;
      nxt_act_high_cmp = high_compare_ff;
    end else if (control_ff[timer_pkg::CTL_UPDATE_EN] && (long_mode ? high_ovf : low_ovf)) begin
      nxt_act_low_cmp  = low_compare_ff;
      nxt_act_high_cmp = high_compare_ff;
    end else begin
      nxt_act_low_cmp  = act_low_cmp_ff;
      nxt_act_high_cmp = act_high_cmp_ff;
    end

    // Long mode: large period of small periods
    // Small period: one full low counter lap
    // High reload sets the small period count
    // Low compare sets the low time of each
    // Some small periods get one more low clock
    // Their count is the high compare, scaled
    // Scaling drops bits the length cannot use
    // Wider periods come first in the large one
    // Variable length: small periods per large period from high reload
    period_cnt = timer_pkg::SMALL_PERIOD - {1'b0, high_reload_ff};
    period_idx = high_counter_ff - high_reload_ff;
    // Scaling by period count drops the high compare bits beyond the length
    extra_prod = {9'h000, act_high_cmp_ff} * {8'h00, period_cnt};
    // First periods of the large period get one extra low clock
    extra_low  = period_idx < extra_prod[15:8];
    low_limit  = {1'b0, act_low_cmp_ff} + {8'h00, extra_low};

    // Pulse flop then pin flop: pin lags by two
    // Equal lag on both edges keeps widths exact
    // Waveform low until counter reaches the compare value
    if (long_mode) begin
      nxt_pulse = {1'b0, low_counter_ff} >= low_limit;
    end else begin
      nxt_pulse = low_counter_ff >= act_low_cmp_ff;
    end

    // Port data bit drives the pin otherwise
    // Pin shows the waveform only when its function selects the timer
    nxt_pin = pin_control_ff[timer_pkg::PIN_SEL_TIMER] ? pulse_ff :
              pin_control_ff[timer_pkg::PIN_PORT_DATA];

    // Request is a level, not a pulse
    // Drops the cycle after the flag clears
    // Request while any flag meets its enable
    nxt_irq = (control_ff[timer_pkg::CTL_HIGH_OVF] & control_ff[timer_pkg::CTL_HIGH_IE]) |
              (control_ff[timer_pkg::CTL_LOW_OVF] & control_ff[timer_pkg::CTL_LOW_IE]);
    // Vector address is fixed
    nxt_vector = timer_pkg::IRQ_VECTOR;
  end

  // Synchronous reset clears every register but the vector
  // Vector flop reloads its fixed address
  // Counters restart at the zero reload value
  // Timer registers, all but the vector cleared by reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      control_ff      <= timer_pkg::BYTE_RESET;
      high_reload_ff  <= timer_pkg::BYTE_RESET;
      low_reload_ff   <= timer_pkg::BYTE_RESET;
      low_compare_ff  <= timer_pkg::BYTE_RESET;
      high_compare_ff <= timer_pkg::BYTE_RESET;
      high_counter_ff <= timer_pkg::BYTE_RESET;
      low_counter_ff  <= timer_pkg::BYTE_RESET;
      act_low_cmp_ff  <= timer_pkg::BYTE_RESET;
      act_high_cmp_ff <= timer_pkg::BYTE_RESET;
      half_ff         <= 1'b0;
      pin_control_ff  <= timer_pkg::PIN_CTL_RESET;
      pulse_ff        <= 1'b0;
      pin_ff          <= 1'b0;
      irq_ff          <= 1'b0;
      vector_ff       <= timer_pkg::IRQ_VECTOR;
    end else begin
      control_ff      <= nxt_control;
      high_reload_ff  <= nxt_high_reload;
      low_reload_ff   <= nxt_low_reload;
      low_compare_ff  <= nxt_low_compare;
      high_compare_ff <= nxt_high_compare;
      high_counter_ff <= nxt_high_counter;
      low_counter_ff  <= nxt_low_counter;
      act_low_cmp_ff  <= nxt_act_low_cmp;
      act_high_cmp_ff <= nxt_act_high_cmp;
      half_ff         <= nxt_half;
      pin_control_ff  <= nxt_pin_control;
      pulse_ff        <= nxt_pulse;
      pin_ff          <= nxt_pin;
      irq_ff          <= nxt_irq;
      vector_ff       <= nxt_vector;
    end
  end

endmodule : dual_reload_timer_pulse_gen

// [verilog/timer_pkg.sv]
// Constants for the dual reload timer and pulse generator
// What this block does
// - Dual mode: two independent 8-bit reload timers
// - Run bit starts; clearing stops and reloads
// - Overflow sets flag, reloads, keeps counting
// - Interrupt request when flag and enable set
// - Pulse mode: high timer, low pulse generator
// - Output low from reload until compare value
// - Pulse period 256 minus reload; flag per overflow
// - New low compare applies next period only
// - 16-bit: low overflow clocks the high counter
// - 16-bit clock full, or half when high stopped
// - In 16-bit, low run controls all bits
// - Variable pulse sets high flag on overflow
// - High reload selects length 9 to 16 bits
// - Large period of up to 256 small periods
// - Low compare plus high compare give low time
// - Only allowed upper high compare bits count
// - 14-bit: 64 minus hc normal, hc wider
// - New compare waits for longest period end
// - Long mode bit selects 8 or 16 bits
// - Compare loads on low or high overflow
// - Interrupt vectors to address 002BH
package timer_pkg;
  // Register indices, byte address is four times the index
  localparam logic [9:0] IDX_CONTROL      = 10'h118;
  localparam logic [9:0] IDX_LOW_COMPARE  = 10'h11A;
  localparam logic [9:0] IDX_LOW          = 10'h11B;
  localparam logic [9:0] IDX_HIGH_COMPARE = 10'h11C;
  localparam logic [9:0] IDX_HIGH         = 10'h11D;
  localparam logic [9:0] IDX_PIN_CONTROL  = 10'h11E;
  // Bus address width
  localparam int         ADDR_W           = 12;
  // Control register fields
  localparam int         CTL_HIGH_RUN     = 7;
  localparam int         CTL_LOW_RUN      = 6;
  localparam int         CTL_LONG_MODE    = 5;
  localparam int         CTL_UPDATE_EN    = 4;
  localparam int         CTL_HIGH_OVF     = 3;
  localparam int         CTL_HIGH_IE      = 2;
  localparam int         CTL_LOW_OVF      = 1;
  localparam int         CTL_LOW_IE       = 0;
  // Pin control fields
  localparam int         PIN_SEL_TIMER    = 0;
  localparam int         PIN_PORT_DATA    = 1;
  // Reset and counting values
  localparam logic [7:0] BYTE_RESET       = 8'h00;
  localparam logic [1:0] PIN_CTL_RESET    = 2'h0;
  localparam logic [7:0] COUNTER_TOP      = 8'hFF;
  localparam logic [7:0] COUNT_STEP       = 8'h01;
  localparam logic [8:0] SMALL_PERIOD     = 9'h100;
  // Interrupt vector address
  localparam logic [15:0] IRQ_VECTOR      = 16'h002B;
  // Bus responses
  localparam logic [1:0] RESP_OKAY        = 2'h0;
  localparam logic [1:0] RESP_SLVERR      = 2'h2;
endpackage : timer_pkg
